// [logic/rio_status_trigger.sv]
// Remote I/O status, alarm, error class and real-time trigger capture with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
`include "rio_regs.svh"

module rio_status_trigger #(
  parameter int unsigned      PULSE_CYC = `RIO_PULSE_MS * (`RIO_CLK_HZ / 1000),
  parameter longint unsigned  ALM_CYC   = 64'(`RIO_ALM_MIN) * 64'd60 * 64'(`RIO_CLK_HZ)
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic [7:0]         remote_op_in,
  input  wire logic [4:0]         robot_select_bit,
  input  wire logic               alive_in,
  input  wire logic [7:0]         rt_trigger_in,
  input  wire logic [15:0]        motor_on,
  input  wire logic [15:0]        at_home,
  input  wire logic [15:0]        high_power,
  input  wire logic [15:0]        cal_missing,
  input  wire logic               ctrl_alarm,
  input  wire logic [15:0]        robot_alarm,
  input  wire logic               battery_alarm,
  input  wire logic               grease_alarm,
  input  wire logic [15:0][31:0]  robot_pos,
  input  wire logic [15:0][31:0]  robot_torque,
  output logic [5:0]              active_function_bit,
  output rio_pkg::rio_status_t    status,
  output logic [31:0]             position_out,
  output logic [31:0]             torque_out,
  output logic                    alive_out,
  output logic [7:0]              remote_op_strobe
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [20:0] PULSE_LAST = 21'(PULSE_CYC - 1);
  localparam logic [33:0] ALM_LAST   = 34'(ALM_CYC - 1);

  // Robot index for data words; none or out of range gives robot 1
  function automatic logic [3:0] sel_idx(input logic [4:0] sel);
    if (sel == 5'h00 || sel > `RIO_SEL_MAX) begin
      sel_idx = 4'h0;
    end else begin
      sel_idx = 4'(sel - 5'h01);
    end
  endfunction : sel_idx

  // Status per select: zero or out of range means all robots
  function automatic logic pick(input logic [15:0] v, input logic [4:0] sel,
                                input logic all_and);
    if (sel == 5'h00 || sel > `RIO_SEL_MAX) begin
      pick = all_and ? &v : |v;
    end else begin
      pick = v[sel_idx(sel)];
    end
  endfunction : pick

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merge[b*8 +: 8] = d[b*8 +: 8];
      end
    end
  endfunction : merge

  function automatic logic in_rng(input logic [13:0] c, input logic [13:0] lo,
                                  input logic [13:0] hi);
    in_rng = (c >= lo) && (c <= hi);
  endfunction : in_rng

  rio_pkg::rio_state_t s_r;
  rio_pkg::rio_state_t s_nxt;
  logic [31:0]         ctrl_word;
  logic [31:0]         ctrl_new;
  logic                rem_en;
  logic [7:0]          rd_clr;
  logic [7:0]          wr_a;
  logic [7:0]          rd_a;
  logic [2:0]          ti;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    rd_clr = 8'h00;
    ctrl_word = 32'h0;
    ctrl_word[`RIO_CTRL_AUTO]   = s_r.ctrl.auto_mode;
    ctrl_word[`RIO_CTRL_REMOTE] = s_r.ctrl.ctrl_remote;
    ctrl_word[`RIO_CTRL_PROG]   = s_r.ctrl.program_mode;
    ctrl_word[`RIO_CTRL_RIOEN]  = s_r.ctrl.rio_en;
    ctrl_word[`RIO_CTRL_MAINT]  = s_r.ctrl.maint_en;
    ctrl_word[`RIO_CTRL_FUNC_HI:`RIO_CTRL_FUNC_LO] = s_r.ctrl.func;
    ctrl_new = merge(ctrl_word, s_r.wdata, s_r.wstrb);
    wr_a = s_r.awaddr;
    rd_a = s_axi_araddr;
    ti = 3'h0;

    // Pin synchronisers
    s_nxt.rem_s1   = remote_op_in;
    s_nxt.rem_s2   = s_r.rem_s1;
    s_nxt.sel_s1   = robot_select_bit;
    s_nxt.sel_s2   = s_r.sel_s1;
    s_nxt.alive_s1 = alive_in;
    s_nxt.alive_s2 = s_r.alive_s1;
    s_nxt.trig_s1  = rt_trigger_in;
    s_nxt.trig_s2  = s_r.trig_s1;
    s_nxt.trig_s3  = s_r.trig_s2;

    s_nxt.alive_out = s_r.alive_s2;

    rem_en = (s_r.ctrl.auto_mode & s_r.ctrl.ctrl_remote)
           | (s_r.ctrl.program_mode & s_r.ctrl.rio_en);

    // Selected robot status and data
    s_nxt.status.motors_on = pick(motor_on, s_r.sel_s2, 1'b0);
    s_nxt.status.at_home = pick(at_home, s_r.sel_s2, 1'b1);
    s_nxt.status.high_power_status = pick(high_power, s_r.sel_s2, 1'b0);
    s_nxt.status.calibration_required_status = pick(cal_missing, s_r.sel_s2, 1'b0);
    s_nxt.pos_out = robot_pos[sel_idx(s_r.sel_s2)];
    s_nxt.trq_out = robot_torque[sel_idx(s_r.sel_s2)];
    s_nxt.status.remote_enabled = rem_en;

    // Periodic battery and grease check
    if (s_r.alm_cnt >= ALM_LAST) begin
      s_nxt.alm_cnt = 34'h0;
      s_nxt.maint_alm = battery_alarm | grease_alarm;
    end else begin
      s_nxt.alm_cnt = s_r.alm_cnt + 34'h1;
    end
    s_nxt.status.alarm = ctrl_alarm | (|robot_alarm)
                       | (s_r.maint_alm & s_r.ctrl.maint_en);

    s_nxt.status.error = in_rng(s_r.code, `RIO_ERR_LO, `RIO_ERR_HI);
    s_nxt.status.system_error_status = in_rng(s_r.code, `RIO_SYS_LO, `RIO_SYS_HI);
    s_nxt.status.warning = in_rng(s_r.code, `RIO_WARN_LO, `RIO_WARN_HI);

    // Remote operation pulse qualifier
    s_nxt.strobe = 8'h00;
    case (s_r.st)
      rio_pkg::RIO_IDLE: begin
        s_nxt.cnt = 21'h0;
        s_nxt.seen = s_r.rem_s2;
        if (|s_r.rem_s2) begin
          s_nxt.st = rio_pkg::RIO_QUAL;
        end
      end
      rio_pkg::RIO_QUAL: begin
        s_nxt.seen = s_r.seen | s_r.rem_s2;
        s_nxt.cnt = s_r.cnt + 21'h1;
        if (s_r.rem_s2 == 8'h00) begin
          s_nxt.st = rio_pkg::RIO_IDLE;
        end else if (s_r.cnt >= PULSE_LAST) begin
          s_nxt.st = rio_pkg::RIO_HELD;
          if ($onehot(s_nxt.seen)) begin
            if (rem_en) begin
              s_nxt.strobe = s_nxt.seen;
            end
          end else begin
            s_nxt.status.remote_error = 1'b1;
          end
        end
      end
      rio_pkg::RIO_HELD: begin
        if (s_r.rem_s2 == 8'h00) begin
          s_nxt.st = rio_pkg::RIO_IDLE;
        end
      end
      default: begin
        s_nxt.st = rio_pkg::RIO_IDLE;
      end
    endcase

    // AXI write channels
    if (s_axi_awvalid && s_r.awrdy) begin
      s_nxt.awv = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wrdy) begin
      s_nxt.wv = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.awv && s_r.wv && !s_r.bvalid) begin
      s_nxt.awv = 1'b0;
      s_nxt.wv = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `RIO_RESP_OKAY;
      if (wr_a == `RIO_CTRL_OFS) begin
        s_nxt.ctrl.auto_mode = ctrl_new[`RIO_CTRL_AUTO];
        s_nxt.ctrl.ctrl_remote = ctrl_new[`RIO_CTRL_REMOTE];
        s_nxt.ctrl.program_mode = ctrl_new[`RIO_CTRL_PROG];
        s_nxt.ctrl.rio_en = ctrl_new[`RIO_CTRL_RIOEN];
        s_nxt.ctrl.maint_en = ctrl_new[`RIO_CTRL_MAINT];
        s_nxt.ctrl.func = ctrl_new[`RIO_CTRL_FUNC_HI:`RIO_CTRL_FUNC_LO];
      end else if (wr_a == `RIO_STATUS_OFS) begin
        // Write one clears; a new error in this cycle wins
        if (s_r.wstrb[1] && s_r.wdata[`RIO_STAT_RERR]
            && !(s_r.st == rio_pkg::RIO_QUAL && s_nxt.st == rio_pkg::RIO_HELD
                 && !$onehot(s_nxt.seen))) begin
          s_nxt.status.remote_error = 1'b0;
        end
      end else if (wr_a == `RIO_CODE_OFS) begin
        s_nxt.code = 14'(merge({18'h0, s_r.code}, s_r.wdata, s_r.wstrb));
      end else if (wr_a == `RIO_PEND_OFS
                   || (wr_a >= `RIO_TPOS_OFS && wr_a <= `RIO_TPOS_END)) begin
        s_nxt.bresp = `RIO_RESP_OKAY;
      end else begin
        s_nxt.bresp = `RIO_RESP_SLVERR;
      end
    end

    // AXI read channel
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arrdy) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `RIO_RESP_OKAY;
      s_nxt.rdata = 32'h0;
      if (rd_a == `RIO_CTRL_OFS) begin
        s_nxt.rdata = ctrl_word;
      end else if (rd_a == `RIO_STATUS_OFS) begin
        s_nxt.rdata = {21'h0, s_r.alive_out, s_r.status};
      end else if (rd_a == `RIO_CODE_OFS) begin
        s_nxt.rdata = {18'h0, s_r.code};
      end else if (rd_a == `RIO_PEND_OFS) begin
        s_nxt.rdata = {24'h0, s_r.pend};
      end else if (rd_a >= `RIO_TPOS_OFS && rd_a <= `RIO_TPOS_END) begin
        ti = 3'((rd_a - `RIO_TPOS_OFS) >> 2);
        s_nxt.rdata = s_r.tpos[ti];
        rd_clr[ti] = 1'b1;
      end else begin
        s_nxt.rresp = `RIO_RESP_SLVERR;
      end
    end

    // Real-time trigger capture; an edge in the reading cycle still lands
    for (int i = 0; i < 8; i++) begin
      if (s_r.trig_s2[i] && !s_r.trig_s3[i] && (!s_r.pend[i] || rd_clr[i])) begin
        s_nxt.tpos[i] = robot_pos[sel_idx(s_r.sel_s2)];
        s_nxt.pend[i] = 1'b1;
      end else if (rd_clr[i]) begin
        s_nxt.pend[i] = 1'b0;
      end
    end

    s_nxt.awrdy = !s_nxt.awv && !s_nxt.bvalid;
    s_nxt.wrdy = !s_nxt.wv && !s_nxt.bvalid;
    s_nxt.arrdy = !s_nxt.rvalid;

    if (!aresetn) begin
      s_nxt = '0;
      s_nxt.st = rio_pkg::RIO_IDLE;
      s_nxt.ctrl = 11'(`RIO_CTRL_RST);
      s_nxt.code = `RIO_CODE_RST;
    end
  end

  always_ff @(posedge aclk) begin
    s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready       = s_r.awrdy;
  assign s_axi_wready        = s_r.wrdy;
  assign s_axi_bvalid        = s_r.bvalid;
  assign s_axi_bresp         = s_r.bresp;
  assign s_axi_arready       = s_r.arrdy;
  assign s_axi_rvalid        = s_r.rvalid;
  assign s_axi_rdata         = s_r.rdata;
  assign s_axi_rresp         = s_r.rresp;
  assign active_function_bit = s_r.ctrl.func;
  assign status              = s_r.status;
  assign position_out        = s_r.pos_out;
  assign torque_out          = s_r.trq_out;
  assign alive_out           = s_r.alive_out;
  assign remote_op_strobe    = s_r.strobe;

endmodule : rio_status_trigger
`default_nettype wire

// [logic/rio_regs.svh]
// Register map, field positions and timing constants of the remote I/O status block
`ifndef RIO_REGS_SVH
`define RIO_REGS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define RIO_CTRL_OFS      8'h00
`define RIO_STATUS_OFS    8'h04
`define RIO_CODE_OFS      8'h08
`define RIO_PEND_OFS      8'h0c
`define RIO_TPOS_OFS      8'h10
`define RIO_TPOS_END      8'h2c
// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define RIO_CTRL_AUTO     0
`define RIO_CTRL_REMOTE   1
`define RIO_CTRL_PROG     2
`define RIO_CTRL_RIOEN    3
`define RIO_CTRL_MAINT    4
`define RIO_CTRL_FUNC_LO  8
`define RIO_CTRL_FUNC_HI  13
`define RIO_CTRL_RST      32'h0000_0000
`define RIO_CODE_RST      14'h0000
`define RIO_STAT_RERR     9
// ----------------------------------------------------------------
// Code classes
// ----------------------------------------------------------------
`define RIO_ERR_LO        14'h03e8
`define RIO_ERR_HI        14'h2327
`define RIO_SYS_LO        14'h2328
`define RIO_SYS_HI        14'h270f
`define RIO_WARN_LO       14'h019a
`define RIO_WARN_HI       14'h03e7
// ----------------------------------------------------------------
// Timing, counter widths, robot count, select limit and response codes
// ----------------------------------------------------------------
`define RIO_CLK_HZ        50000000
`define RIO_PULSE_MS      25
`define RIO_ALM_MIN       5
`define RIO_PULSE_CW      21
`define RIO_ALM_CW        34
`define RIO_NROBOT        16
`define RIO_SEL_MAX       5'h10
`define RIO_RESP_OKAY     2'h0
`define RIO_RESP_SLVERR   2'h2
`endif

// [logic/rio_pkg.sv]
// Types of the remote I/O status block
`default_nettype none
package rio_pkg;
  typedef enum logic [2:0] {
    RIO_IDLE = 3'h1,
    RIO_QUAL = 3'h2,
    RIO_HELD = 3'h4
  } rio_st_t;

  typedef struct packed {
    logic [5:0] func;
    logic       maint_en;
    logic       rio_en;
    logic       program_mode;
    logic       ctrl_remote;
    logic       auto_mode;
  } rio_ctrl_t;

  typedef struct packed {
    logic remote_error;
    logic remote_enabled;
    logic warning;
    logic system_error_status;
    logic error;
    logic alarm;
    logic calibration_required_status;
    logic high_power_status;
    logic at_home;
    logic motors_on;
  } rio_status_t;

  typedef struct packed {
    rio_st_t            st;
    logic [20:0]        cnt;
    logic [7:0]         seen;
    logic [33:0]        alm_cnt;
    logic               maint_alm;
    logic [7:0]         rem_s1;
    logic [7:0]         rem_s2;
    logic [4:0]         sel_s1;
    logic [4:0]         sel_s2;
    logic               alive_s1;
    logic               alive_s2;
    logic [7:0]         trig_s1;
    logic [7:0]         trig_s2;
    logic [7:0]         trig_s3;
    rio_ctrl_t          ctrl;
    logic [13:0]        code;
    logic [7:0]         pend;
    logic [7:0][31:0]   tpos;
    logic [7:0]         strobe;
    rio_status_t        status;
    logic [31:0]        pos_out;
    logic [31:0]        trq_out;
    logic               alive_out;
    logic               awv;
    logic [7:0]         awaddr;
    logic               wv;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               awrdy;
    logic               wrdy;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arrdy;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
  } rio_state_t;
endpackage : rio_pkg
`default_nettype wire

// [testbench/rio_status_trigger_assertions.sv]
// Port-level checks of the remote I/O status and trigger block
`timescale 1ns/10ps
`default_nettype none
module rio_status_trigger_assertions #(
  parameter int unsigned PULSE_CYC = 8
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic [7:0]           s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic [7:0]           remote_op_in,
  input wire logic [4:0]           robot_select_bit,
  input wire logic                 alive_in,
  input wire logic [15:0]          motor_on,
  input wire logic [15:0]          at_home,
  input wire logic [15:0]          high_power,
  input wire logic [15:0]          cal_missing,
  input wire logic                 ctrl_alarm,
  input wire logic [15:0]          robot_alarm,
  input wire logic [15:0][31:0]    robot_pos,
  input wire rio_pkg::rio_status_t status,
  input wire logic [31:0]          position_out,
  input wire logic                 alive_out,
  input wire logic [7:0]           remote_op_strobe
);
  // ----------------------------------------------------------------
  // Delay lines matching pin-to-output latency
  // ----------------------------------------------------------------
  logic [14:0]       sp;
  logic [3:0][15:0]  vd;
  logic [15:0][31:0] pd;
  logic [3:0]        rc;
  logic [7:0]        op_q;
  int unsigned       hi;
  always_ff @(posedge aclk) begin
    sp <= {sp[9:0], robot_select_bit};
    vd <= {motor_on, at_home, high_power, cal_missing};
    pd <= robot_pos;
    op_q <= remote_op_in;
    if (remote_op_in != 8'h00) hi <= (op_q == 8'h00) ? 1 : hi + 1;
    if (!aresetn) rc <= 4'h0;
    else if (rc != 4'hf) rc <= rc + 4'h1;
  end
  wire       ok    = rc > 4'h4;
  wire       all_s = sp[14:10] == 5'h00 || sp[14:10] > 5'h10;
  wire [3:0] ix    = all_s ? 4'h0 : 4'(sp[14:10] - 5'h01);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence op_fire;
    remote_op_strobe != 8'h00;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_motor_map: assert property (ok |-> status.motors_on == (all_s ? |vd[3] : vd[3][ix]))
    else $error("motor status does not follow select");
  a_home_map: assert property (ok |-> status.at_home == (all_s ? &vd[2] : vd[2][ix]))
    else $error("home status does not follow select");
  a_power_map: assert property (ok |-> status.high_power_status == (all_s ? |vd[1] : vd[1][ix]))
    else $error("high power status does not follow select");
  a_cal_map: assert property (ok |-> status.calibration_required_status == (all_s ? |vd[0] : vd[0][ix]))
    else $error("calibration status does not follow select");
  a_pos_robot: assert property (ok |-> position_out == pd[ix])
    else $error("position is not from the selected robot");
  a_alive_copy: assert property (ok |-> alive_out == $past(alive_in, 3))
    else $error("alive output does not follow input");
  a_alarm_src: assert property (ok && $past(ctrl_alarm || robot_alarm != 16'h0) |-> status.alarm)
    else $error("alarm output missing");
  a_op_single: assert property (op_fire |-> $onehot(remote_op_strobe) && status.remote_enabled)
    else $error("operation strobe not single or not enabled");
  a_op_pulse: assert property (op_fire |=> remote_op_strobe == 8'h00)
    else $error("operation strobe longer than one cycle");
  a_op_width: assert property (op_fire |-> hi >= PULSE_CYC)
    else $error("operation accepted from a short pulse");
  a_rd_unmapped: assert property (rd_take ##0 (s_axi_araddr > 8'h2c) |=>
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_answer: assert property (rd_take ##0 (s_axi_araddr <= 8'h2c) |=> s_axi_rvalid && s_axi_rresp == 2'h0)
    else $error("mapped read not answered");
endmodule : rio_status_trigger_assertions

bind rio_status_trigger rio_status_trigger_assertions #(.PULSE_CYC(PULSE_CYC)) i_rio_chk (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .remote_op_in, .robot_select_bit, .alive_in, .motor_on, .at_home, .high_power,
  .cal_missing, .ctrl_alarm, .robot_alarm, .robot_pos, .status, .position_out, .alive_out,
  .remote_op_strobe
);
`default_nettype wire

// [testbench/rio_master_model.sv]
// Master equipment model driving remote operation and robot select pins
`timescale 1ns/10ps
`default_nettype none
module rio_master_model #(
  parameter int SEL_WAIT = 6
) (
  input wire logic  aclk,
  output logic [7:0] remote_op_in,
  output logic [4:0] robot_select_bit
);
  initial begin
    remote_op_in = 8'h00;
    robot_select_bit = 5'h00;
  end
  task automatic pulse(input logic [7:0] m, input int len);
    @(posedge aclk);
    remote_op_in <= m;
    repeat (len) @(posedge aclk);
    remote_op_in <= 8'h00;
  endtask : pulse
  task automatic sel_robot(input logic [4:0] v);
    @(posedge aclk);
    robot_select_bit <= v;
    repeat (SEL_WAIT) @(posedge aclk);
  endtask : sel_robot
endmodule : rio_master_model
`default_nettype wire

// [testbench/tb_rio_status_trigger.sv]
// Self-checking bench of the remote I/O status and trigger block
`timescale 1ns/10ps
`default_nettype none
module tb_rio_status_trigger;
  localparam int PC = 8;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rt_trigger_in = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic alive_in = 0, ctrl_alarm = 0, battery_alarm = 0, grease_alarm = 0;
  logic [15:0] motor_on = '0, at_home = '0, high_power = '0, cal_missing = '0, robot_alarm = '0;
  logic [15:0][31:0] robot_pos, robot_torque;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, alive_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, position_out, torque_out;
  logic [7:0] remote_op_in, remote_op_strobe, last_stb;
  logic [5:0] active_function_bit;
  logic [4:0] robot_select_bit;
  rio_pkg::rio_status_t status;
  int mismatches = 0, n_compared = 0, cyc = 0, n_stb = 0;

  rio_status_trigger #(.PULSE_CYC(PC), .ALM_CYC(64'd16)) i_rio_status_trigger (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .remote_op_in, .robot_select_bit, .alive_in, .rt_trigger_in, .motor_on, .at_home,
    .high_power, .cal_missing, .ctrl_alarm, .robot_alarm, .battery_alarm, .grease_alarm,
    .robot_pos, .robot_torque, .active_function_bit, .status, .position_out, .torque_out,
    .alive_out, .remote_op_strobe);
  rio_master_model #(.SEL_WAIT(6)) i_rio_master_model (.aclk, .remote_op_in, .robot_select_bit);

  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (|remote_op_strobe) n_stb++;
    if (|remote_op_strobe) last_stb = remote_op_strobe;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    chk("bresp", {1'b1, er}, {s_axi_bvalid, s_axi_bresp});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {1'b1, er}, {s_axi_rvalid, s_axi_rresp});
  endtask : rd

  task automatic t_regs();
    logic [31:0] d;
    rd(8'h00, d, 2'h0);
    chk("ctrl reset", 32'h0, d);
    rd(8'h0c, d, 2'h0);
    chk("pend reset", 32'h0, d);
    rd(8'h30, d, 2'h2);
    chk("unmapped data", 32'h0, d);
    wr(8'h30, 32'hffff_ffff, 2'h2);
    rd(8'h00, d, 2'h0);
    chk("ctrl untouched", 32'h0, d);
    $display("test regs end");
  endtask : t_regs
  task automatic t_func();
    logic [5:0] f[4] = '{6'h00, 6'h01, 6'h2a, 6'h3f};
    foreach (f[i]) begin
      wr(8'h00, {18'h0, f[i], 8'h00}, 2'h0);
      wt(2);
      chk("function bits", f[i], active_function_bit);
    end
    $display("test function end");
  endtask : t_func
  task automatic t_stat();
    logic [4:0] s[4] = '{5'h00, 5'h01, 5'h05, 5'h10};
    logic a;
    logic [3:0] x;
    motor_on <= 16'h8010;
    at_home <= 16'hfffe;
    high_power <= 16'h0001;
    cal_missing <= 16'h8000;
    foreach (s[i]) begin
      i_rio_master_model.sel_robot(s[i]);
      a = s[i] == 5'h00;
      x = a ? 4'h0 : 4'(s[i] - 5'h01);
      chk("motors", a ? |motor_on : motor_on[x], status.motors_on);
      chk("home", a ? &at_home : at_home[x], status.at_home);
      chk("power", a ? |high_power : high_power[x], status.high_power_status);
      chk("cal", a ? |cal_missing : cal_missing[x], status.calibration_required_status);
      chk("position", robot_pos[x], position_out);
      chk("torque", robot_torque[x], torque_out);
    end
    $display("test status end");
  endtask : t_stat
  task automatic t_alarm();
    logic [3:0] st[4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [3:0] ex[4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    wr(8'h00, 32'h0, 2'h0);
    foreach (st[i]) begin
      if (i == 3) wr(8'h00, 32'h10, 2'h0);
      {ctrl_alarm, robot_alarm[9], battery_alarm, grease_alarm} <= st[i];
      wt(40);
      chk("alarm", ex[i], status.alarm);
    end
    {battery_alarm, grease_alarm} <= 2'b10;
    wt(40);
    chk("battery alarm", 1'b1, status.alarm);
    battery_alarm <= 1'b0;
    wt(40);
    chk("alarm clear", 1'b0, status.alarm);
    $display("test alarm end");
  endtask : t_alarm
  task automatic t_code();
    logic [13:0] c[9] = '{14'h0199, 14'h019a, 14'h03e7, 14'h03e8, 14'h2327, 14'h2328,
                          14'h232f, 14'h270f, 14'h2710};
    foreach (c[i]) begin
      wr(8'h08, {18'h0, c[i]}, 2'h0);
      wt(2);
      chk("warning", c[i] >= 14'h019a && c[i] <= 14'h03e7, status.warning);
      chk("error", c[i] >= 14'h03e8 && c[i] <= 14'h2327, status.error);
      chk("sys error", c[i] >= 14'h2328 && c[i] <= 14'h270f, status.system_error_status);
    end
    $display("test code end");
  endtask : t_code
  task automatic t_remote();
    logic [31:0] m[7] = '{32'h00, 32'h01, 32'h02, 32'h03, 32'h04, 32'h08, 32'h0c};
    logic e;
    int n;
    foreach (m[i]) begin
      wr(8'h00, m[i], 2'h0);
      e = (m[i][0] & m[i][1]) | (m[i][2] & m[i][3]);
      n = n_stb;
      i_rio_master_model.pulse(8'h01 << i, PC + 3);
      wt(6);
      chk("enabled", e, status.remote_enabled);
      chk("strobes", n + e, n_stb);
      if (e) chk("strobe bit", 8'h01 << i, last_stb);
    end
    n = n_stb;
    i_rio_master_model.pulse(8'h12, PC + 3);
    wt(6);
    chk("double op", n, n_stb);
    chk("remote error", 1'b1, status.remote_error);
    wr(8'h04, 32'h200, 2'h0);
    wt(2);
    chk("error clear", 1'b0, status.remote_error);
    $display("test remote end");
  endtask : t_remote
  task automatic t_trig();
    logic [31:0] d;
    i_rio_master_model.sel_robot(5'h03);
    for (int i = 0; i < 9; i++) begin
      robot_pos[2] <= (i < 8) ? 32'h4100_0000 + i : 32'h4200_0000;
      rt_trigger_in[i % 8] <= 1'b1;
      wt(5);
      rt_trigger_in[i % 8] <= 1'b0;
      wt(2);
    end
    rd(8'h0c, d, 2'h0);
    chk("pending", 32'hff, d);
    for (int i = 0; i < 8; i++) begin
      rd(8'(8'h10 + 4 * i), d, 2'h0);
      chk("captured", 32'h4100_0000 + i, d);
    end
    rd(8'h0c, d, 2'h0);
    chk("pending read", 32'h0, d);
    alive_in <= 1'b1;
    wt(4);
    chk("alive", 1'b1, alive_out);
    alive_in <= 1'b0;
    wt(4);
    chk("alive", 1'b0, alive_out);
    $display("test trigger end");
  endtask : t_trig

  initial begin
    for (int k = 0; k < 16; k++) begin
      robot_pos[k] = 32'h3f80_0000 + k;
      robot_torque[k] = 32'h4000_0000 + k;
    end
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    wt(2);
    t_regs();
    t_func();
    t_stat();
    t_alarm();
    t_code();
    t_remote();
    t_trig();
    wrap_up();
  end
endmodule : tb_rio_status_trigger
`default_nettype wire
